//--- arc_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH
`define ARC_OFF_MIXER        11'h522
`define ARC_OFF_ANALOG       11'h523
`define ARC_OFF_PORT         11'h524
`define ARC_MIXER_RST        32'h0000_3300
`define ARC_ANALOG_RST       32'h0000_0000
`define ARC_PORT_RST         32'h0000_0000
`define ARC_MIXER_MASK       32'h0f0f_3f80
`define ARC_ANALOG_MASK      32'h0100_1fff
`define ARC_PORT_MASK        32'h0000_001f
`define ARC_MIX_ZXOFF        7
`define ARC_MIX_GAIN_LO      8
`define ARC_MIX_SERIAL_DSP   16
`define ARC_MIX_CONV_DSP     17
`define ARC_MIX_TX_LO        18
`define ARC_MIX_A_LO         24
`define ARC_MIX_B_LO         26
`define ARC_ANA_GAIN_LO      0
`define ARC_ANA_PARALLEL     2
`define ARC_ANA_IDLE_ANA     3
`define ARC_ANA_IDLE_SER     4
`define ARC_ANA_TRIM         5
`define ARC_ANA_FAULT_OFF    6
`define ARC_ANA_BYPASS       7
`define ARC_ANA_SHORT_IN     8
`define ARC_ANA_SCP_OFF      9
`define ARC_ANA_TSD_OFF      10
`define ARC_ANA_PMC_PLL      11
`define ARC_ANA_SINGLE_EDGE  12
`define ARC_ANA_GAIN_SRC     24
`define ARC_PORT_STEREO      0
`define ARC_PORT_RX          1
`define ARC_PORT_TX          2
`define ARC_PORT_BCLK_ROLE   3
`define ARC_PORT_WS_ROLE     4
`define ARC_BCLK_DIV         8'd4
`define ARC_WS_HALF_BITS     7'd32
`endif

//--- arc_pkg.sv
// shared types of the audio route config block
package arc_pkg;
	typedef enum logic [1:0] {
		ARC_SRC_OFF    = 2'b00,
		ARC_SRC_DSP    = 2'b01,
		ARC_SRC_SERIAL = 2'b10,
		ARC_SRC_CONV   = 2'b11
	} arc_amp_src_t;
	typedef enum logic [1:0] {
		ARC_TX_NONE = 2'b00,
		ARC_TX_CONV = 2'b01,
		ARC_TX_DSP  = 2'b10,
		ARC_TX_RSVD = 2'b11
	} arc_tx_src_t;
	typedef enum logic [1:0] {
		ARC_PG_0DB   = 2'b00,
		ARC_PG_2P4DB = 2'b01,
		ARC_PG_3P5DB = 2'b10,
		ARC_PG_6DB   = 2'b11
	} arc_pre_gain_t;
endpackage : arc_pkg

//--- arc_config_regs.sv
// configuration registers and routing for the stereo amplifier core
`timescale 1ns/1ps
`include "arc_defines.svh"
module arc_config_regs #(
	parameter int GAIN_W = 6,
	parameter int COEF_W = 16
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic                 clk_en,
	input  wire logic                 clk_link,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [10:0]          reg_addr,
	input  wire logic [31:0]          reg_wdata,
	output logic      [31:0]          reg_rdata,
	output logic                      reg_hit,
	input  wire logic                 gain_pin_zero,
	input  wire logic                 gain_pin_one,
	input  wire logic                 analog_active,
	input  wire logic                 serial_active,
	input  wire logic                 fault_short,
	input  wire logic                 fault_thermal,
	input  wire logic [3*COEF_W-1:0]  conv_trim_coeffs,
	input  wire logic                 link_bclk_in,
	input  wire logic                 link_ws_in,
	output logic                      gain_zero_cross_off,
	output logic      [GAIN_W-1:0]    digital_in_gain,
	output logic      [8:0]           digital_gain_half_db,
	output logic                      gain_is_boost,
	output logic                      serial_to_dsp,
	output logic                      conv_to_dsp,
	output logic      [1:0]           primary_tx_source,
	output logic      [1:0]           amp_a_source,
	output logic      [1:0]           amp_b_source,
	output logic                      amp_out_a_en,
	output logic                      amp_out_b_en,
	output logic                      amp_parallel,
	output logic      [1:0]           preamp_gain,
	output logic                      conv_trim_enable,
	output logic      [3*COEF_W-1:0]  conv_trim_applied,
	output logic                      pulse_correct_bypass,
	output logic                      input_short_quiet,
	output logic                      short_protect_off,
	output logic                      thermal_protect_off,
	output logic                      power_mgmt_pll_clock,
	output logic                      single_edge_modulation,
	output logic                      port_stereo,
	output logic                      port_rx_en,
	output logic                      port_tx_en,
	output logic                      link_bclk_out,
	output logic                      link_bclk_oe,
	output logic                      link_ws_out,
	output logic                      link_ws_oe
);
	logic [31:0] mixer_routing_control_q;
	logic [31:0] analog_config_q;
	logic [31:0] serial_port_config_low_q;
	logic        gp0_s1_q, gp0_s2_q, gp1_s1_q, gp1_s2_q;
	logic        ana_s1_q, ana_s2_q, ser_s1_q, ser_s2_q;
	logic        fs_s1_q, fs_s2_q, ft_s1_q, ft_s2_q;
	logic        bclk_s1_q, bclk_s2_q, ws_s1_q, ws_s2_q;
	logic [1:0]  pre_gain_d;
	logic        amp_kill_d;
	logic        fault_d;
	logic        link_run_d;
	logic        drv_bclk_d;
	logic        drv_ws_d;

	// gain code to signed half-dB steps: code 51 is 0 dB, 3 half-dB per code
	function automatic logic [8:0] arc_gain_half_db(input logic [5:0] code);
		logic [8:0] v;
		v = 9'({3'b000, code} * 9'd3) - 9'd153;
		return v;
	endfunction : arc_gain_half_db

	function automatic logic arc_hit(input logic [10:0] a);
		logic h;
		h = 1'b0;
		if (a == `ARC_OFF_MIXER) begin
			h = 1'b1;
		end else if (a == `ARC_OFF_ANALOG) begin
			h = 1'b1;
		end else if (a == `ARC_OFF_PORT) begin
			h = 1'b1;
		end
		return h;
	endfunction : arc_hit

	// register writes; unused bits are held at zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mixer_routing_control_q  <= `ARC_MIXER_RST;
			analog_config_q          <= `ARC_ANALOG_RST;
			serial_port_config_low_q <= `ARC_PORT_RST;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == `ARC_OFF_MIXER) begin
				mixer_routing_control_q <= reg_wdata & `ARC_MIXER_MASK;
			end else if (reg_addr == `ARC_OFF_ANALOG) begin
				analog_config_q <= reg_wdata & `ARC_ANALOG_MASK;
			end else if (reg_addr == `ARC_OFF_PORT) begin
				serial_port_config_low_q <= reg_wdata & `ARC_PORT_MASK;
			end
		end
	end

	// read port; unmapped addresses read zero with reg_hit low
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
			reg_hit   <= 1'b0;
		end else if (clk_en) begin
			reg_hit <= reg_rd && arc_hit(reg_addr);
			if (!reg_rd) begin
				reg_rdata <= 32'h0000_0000;
			end else if (reg_addr == `ARC_OFF_MIXER) begin
				reg_rdata <= mixer_routing_control_q;
			end else if (reg_addr == `ARC_OFF_ANALOG) begin
				reg_rdata <= analog_config_q;
			end else if (reg_addr == `ARC_OFF_PORT) begin
				reg_rdata <= serial_port_config_low_q;
			end else begin
				reg_rdata <= 32'h0000_0000;
			end
		end
	end

	// pin synchronisers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			{gp0_s1_q, gp0_s2_q, gp1_s1_q, gp1_s2_q} <= 4'h0;
			{ana_s1_q, ana_s2_q, ser_s1_q, ser_s2_q} <= 4'h0;
			{fs_s1_q, fs_s2_q, ft_s1_q, ft_s2_q}     <= 4'h0;
		end else if (clk_en) begin
			gp0_s1_q <= gain_pin_zero;
			gp0_s2_q <= gp0_s1_q;
			gp1_s1_q <= gain_pin_one;
			gp1_s2_q <= gp1_s1_q;
			ana_s1_q <= analog_active;
			ana_s2_q <= ana_s1_q;
			ser_s1_q <= serial_active;
			ser_s2_q <= ser_s1_q;
			fs_s1_q  <= fault_short;
			fs_s2_q  <= fs_s1_q;
			ft_s1_q  <= fault_thermal;
			ft_s2_q  <= ft_s1_q;
		end
	end

	always_comb begin
		if (analog_config_q[`ARC_ANA_GAIN_SRC]) begin
			pre_gain_d = analog_config_q[`ARC_ANA_GAIN_LO +: 2];
		end else begin
			pre_gain_d = {gp1_s2_q, gp0_s2_q};
		end
		// a disabled protection does not count as a fault
		fault_d = (fs_s2_q && !analog_config_q[`ARC_ANA_SCP_OFF]) ||
			(ft_s2_q && !analog_config_q[`ARC_ANA_TSD_OFF]);
		amp_kill_d = (analog_config_q[`ARC_ANA_IDLE_ANA] && !ana_s2_q) ||
			(analog_config_q[`ARC_ANA_IDLE_SER] && !ser_s2_q) ||
			(analog_config_q[`ARC_ANA_FAULT_OFF] && fault_d);
	end

	// decoded controls
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			gain_zero_cross_off    <= 1'b0;
			digital_in_gain        <= '0;
			digital_gain_half_db   <= 9'h000;
			gain_is_boost          <= 1'b0;
			serial_to_dsp          <= 1'b0;
			conv_to_dsp            <= 1'b0;
			primary_tx_source      <= 2'b00;
			amp_a_source           <= 2'b00;
			amp_b_source           <= 2'b00;
			amp_out_a_en           <= 1'b0;
			amp_out_b_en           <= 1'b0;
			amp_parallel           <= 1'b0;
			preamp_gain            <= 2'b00;
			conv_trim_enable       <= 1'b0;
			conv_trim_applied      <= '0;
			pulse_correct_bypass   <= 1'b0;
			input_short_quiet      <= 1'b0;
			short_protect_off      <= 1'b0;
			thermal_protect_off    <= 1'b0;
			power_mgmt_pll_clock   <= 1'b0;
			single_edge_modulation <= 1'b0;
			port_stereo            <= 1'b0;
			port_rx_en             <= 1'b0;
			port_tx_en             <= 1'b0;
		end else if (clk_en) begin
			gain_zero_cross_off <= mixer_routing_control_q[`ARC_MIX_ZXOFF];
			digital_in_gain <= GAIN_W'(mixer_routing_control_q[`ARC_MIX_GAIN_LO +: 6]);
			digital_gain_half_db <= arc_gain_half_db(
				mixer_routing_control_q[`ARC_MIX_GAIN_LO +: 6]);
			gain_is_boost <= mixer_routing_control_q[`ARC_MIX_GAIN_LO +: 6] > 6'd51;
			serial_to_dsp <= mixer_routing_control_q[`ARC_MIX_SERIAL_DSP];
			conv_to_dsp   <= mixer_routing_control_q[`ARC_MIX_CONV_DSP];
			// unused transmitter code behaves as none
			if (mixer_routing_control_q[`ARC_MIX_TX_LO +: 2] ==
				arc_pkg::ARC_TX_RSVD) begin
				primary_tx_source <= arc_pkg::ARC_TX_NONE;
			end else begin
				primary_tx_source <= mixer_routing_control_q[`ARC_MIX_TX_LO +: 2];
			end
			amp_a_source <= mixer_routing_control_q[`ARC_MIX_A_LO +: 2];
			amp_b_source <= mixer_routing_control_q[`ARC_MIX_B_LO +: 2];
			amp_parallel <= analog_config_q[`ARC_ANA_PARALLEL];
			amp_out_a_en <= !amp_kill_d && (mixer_routing_control_q[`ARC_MIX_A_LO +: 2]
				!= arc_pkg::ARC_SRC_OFF);
			// in parallel mode amp B follows amp A
			if (analog_config_q[`ARC_ANA_PARALLEL]) begin
				amp_out_b_en <= !amp_kill_d && (mixer_routing_control_q[
					`ARC_MIX_A_LO +: 2] != arc_pkg::ARC_SRC_OFF);
			end else begin
				amp_out_b_en <= !amp_kill_d && (mixer_routing_control_q[
					`ARC_MIX_B_LO +: 2] != arc_pkg::ARC_SRC_OFF);
			end
			preamp_gain <= pre_gain_d;
			conv_trim_enable <= analog_config_q[`ARC_ANA_TRIM];
			conv_trim_applied <= analog_config_q[`ARC_ANA_TRIM] ?
				conv_trim_coeffs : '0;
			pulse_correct_bypass <= analog_config_q[`ARC_ANA_BYPASS];
			input_short_quiet <= analog_config_q[`ARC_ANA_SHORT_IN];
			short_protect_off <= analog_config_q[`ARC_ANA_SCP_OFF];
			thermal_protect_off <= analog_config_q[`ARC_ANA_TSD_OFF];
			power_mgmt_pll_clock <= analog_config_q[`ARC_ANA_PMC_PLL];
			single_edge_modulation <= analog_config_q[`ARC_ANA_SINGLE_EDGE];
			port_stereo <= serial_port_config_low_q[`ARC_PORT_STEREO];
			port_rx_en  <= serial_port_config_low_q[`ARC_PORT_RX];
			port_tx_en  <= serial_port_config_low_q[`ARC_PORT_TX];
		end
	end

	// role requests crossing into the link domain as levels
	always_comb begin
		link_run_d = serial_port_config_low_q[`ARC_PORT_RX] ||
			serial_port_config_low_q[`ARC_PORT_TX];
		drv_bclk_d = link_run_d && serial_port_config_low_q[`ARC_PORT_BCLK_ROLE];
		drv_ws_d   = link_run_d && serial_port_config_low_q[`ARC_PORT_WS_ROLE];
	end

	logic drv_bclk_q, drv_ws_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			drv_bclk_q <= 1'b0;
			drv_ws_q   <= 1'b0;
		end else if (clk_en) begin
			drv_bclk_q <= drv_bclk_d;
			drv_ws_q   <= drv_ws_d;
		end
	end

	// link domain: reset is carried across as a level too
	logic       lrst_s1_q, lrst_s2_q;
	logic       lb_s1_q, lb_s2_q, lw_s1_q, lw_s2_q;
	logic [7:0] bdiv_q;
	logic [5:0] wcnt_q;
	always_ff @(posedge clk_link) begin
		lrst_s1_q <= rst_n;
		lrst_s2_q <= lrst_s1_q;
		lb_s1_q   <= drv_bclk_q;
		lb_s2_q   <= lb_s1_q;
		lw_s1_q   <= drv_ws_q;
		lw_s2_q   <= lw_s1_q;
	end

	always_ff @(posedge clk_link) begin
		if (!lrst_s2_q) begin
			bdiv_q        <= 8'h00;
			wcnt_q        <= 6'h00;
			link_bclk_out <= 1'b0;
			link_bclk_oe  <= 1'b0;
			link_ws_out   <= 1'b0;
			link_ws_oe    <= 1'b0;
		end else begin
			link_bclk_oe <= lb_s2_q;
			link_ws_oe   <= lw_s2_q;
			if (!lb_s2_q && !lw_s2_q) begin
				bdiv_q        <= 8'h00;
				wcnt_q        <= 6'h00;
				link_bclk_out <= 1'b0;
				link_ws_out   <= 1'b0;
			end else if (bdiv_q == `ARC_BCLK_DIV - 8'd1) begin
				bdiv_q        <= 8'h00;
				link_bclk_out <= !link_bclk_out;
				// word select changes on falling bit clock
				if (link_bclk_out) begin
					// half-frame count is wider than the counter, cut on purpose
					if (wcnt_q == 6'(`ARC_WS_HALF_BITS - 7'd1)) begin
						wcnt_q      <= 6'h00;
						link_ws_out <= !link_ws_out;
					end else begin
						wcnt_q <= wcnt_q + 6'd1;
					end
				end
			end else begin
				bdiv_q <= bdiv_q + 8'd1;
			end
		end
	end

	// external bit clock and word select, kept synchronised; no logic reads them
	always_ff @(posedge clk_link) begin
		bclk_s1_q <= link_bclk_in;
		bclk_s2_q <= bclk_s1_q;
		ws_s1_q   <= link_ws_in;
		ws_s2_q   <= ws_s1_q;
	end
endmodule : arc_config_regs

//--- arc_config_regs_assertions.sv
// port assertions for the audio route config register bank
`timescale 1ns/1ps
`include "arc_defines.svh"
module arc_config_regs_chk (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        clk_en,
	input wire logic        clk_link,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [10:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic        reg_hit,
	input wire logic        gain_zero_cross_off,
	input wire logic [5:0]  digital_in_gain,
	input wire logic [8:0]  digital_gain_half_db,
	input wire logic        gain_is_boost,
	input wire logic [1:0]  primary_tx_source,
	input wire logic [1:0]  amp_a_source,
	input wire logic        amp_out_a_en,
	input wire logic        amp_out_b_en,
	input wire logic        amp_parallel,
	input wire logic        link_bclk_out,
	input wire logic        link_bclk_oe
);
	property p_zx;
		@(posedge clk_sys) disable iff (!rst_n)
		clk_en && reg_wr && reg_addr == `ARC_OFF_MIXER ##1 clk_en
		|-> ##1 gain_zero_cross_off == $past(reg_wdata[7], 2);
	endproperty
	a_zx: assert property (p_zx) else $error("zero cross bit wrong");
	property p_gain;
		@(posedge clk_sys) disable iff (!rst_n)
		$past(rst_n) |-> digital_gain_half_db == 9'(digital_in_gain * 3 - 153)
		&& gain_is_boost == (digital_in_gain > 6'd51);
	endproperty
	a_gain: assert property (p_gain) else $error("gain step wrong");
	property p_tx;
		@(posedge clk_sys) disable iff (!rst_n) primary_tx_source != 2'b11;
	endproperty
	a_tx: assert property (p_tx) else $error("unused tx code shown");
	property p_amp;
		@(posedge clk_sys) disable iff (!rst_n)
		amp_out_a_en |-> amp_a_source != 2'b00;
	endproperty
	a_amp: assert property (p_amp) else $error("disabled amp on");
	property p_par;
		@(posedge clk_sys) disable iff (!rst_n)
		amp_parallel |-> amp_out_b_en == amp_out_a_en;
	endproperty
	a_par: assert property (p_par) else $error("parallel amps split");
	property p_miss;
		@(posedge clk_sys) disable iff (!rst_n)
		clk_en && reg_rd && !(reg_addr inside {`ARC_OFF_MIXER, `ARC_OFF_ANALOG,
		`ARC_OFF_PORT}) |=> reg_rdata == 32'h0 && !reg_hit;
	endproperty
	a_miss: assert property (p_miss) else $error("unmapped read answered");
	property p_hit;
		@(posedge clk_sys) disable iff (!rst_n)
		clk_en && reg_rd && reg_addr inside {`ARC_OFF_MIXER, `ARC_OFF_ANALOG,
		`ARC_OFF_PORT} |=> reg_hit;
	endproperty
	a_hit: assert property (p_hit) else $error("mapped read missed");
	property p_mask;
		@(posedge clk_sys) disable iff (!rst_n)
		reg_hit && $past(reg_addr) == `ARC_OFF_ANALOG
		|-> (reg_rdata & 32'hfeff_e000) == 32'h0;
	endproperty
	a_mask: assert property (p_mask) else $error("unused bits read");
	property p_bclk;
		@(posedge clk_link) disable iff (!rst_n)
		link_bclk_oe [*5] |-> link_bclk_out != $past(link_bclk_out, 4);
	endproperty
	a_bclk: assert property (p_bclk) else $error("bit clock rate wrong");
	c_wr: cover property (@(posedge clk_sys) reg_wr && reg_addr == 11'h523);
	c_miss: cover property (@(posedge clk_sys) reg_rd && reg_addr == 11'h521);
	c_oe: cover property (@(posedge clk_link) $rose(link_bclk_oe));
	c_kill: cover property (@(posedge clk_sys) amp_a_source != 0 && !amp_out_a_en);
endmodule : arc_config_regs_chk
bind arc_config_regs arc_config_regs_chk u_arc_config_regs_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .clk_link(clk_link),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
	.gain_zero_cross_off(gain_zero_cross_off),
	.digital_in_gain(digital_in_gain), .gain_is_boost(gain_is_boost),
	.digital_gain_half_db(digital_gain_half_db),
	.primary_tx_source(primary_tx_source), .amp_a_source(amp_a_source),
	.amp_out_a_en(amp_out_a_en), .amp_out_b_en(amp_out_b_en),
	.amp_parallel(amp_parallel), .link_bclk_out(link_bclk_out),
	.link_bclk_oe(link_bclk_oe));

//--- arc_link_host.sv
// far-side serial host that supplies the link clocks when the device is slave
`timescale 1ns/1ps
module arc_link_host (
	input wire logic clk_link,
	input wire logic supply_bclk,
	input wire logic supply_ws,
	output logic     host_bclk,
	output logic     host_ws
);
	logic [4:0] cnt_q = 5'h0;
	// clocks stand still low while not supplied
	always_ff @(posedge clk_link) begin
		cnt_q <= cnt_q + 5'h1;
		host_bclk <= supply_bclk & cnt_q[0];
		host_ws <= supply_ws & cnt_q[4];
	end
endmodule : arc_link_host

//--- tb_top.sv
// self-checking bench for the audio route config register bank
`timescale 1ns/1ps
`include "arc_defines.svh"
module tb_top;
	typedef struct { logic [10:0] a; logic [31:0] d; logic [31:0] e; } arc_row_t;
	typedef struct { logic [12:0] ana; logic [3:0] in; logic [1:0] e; } arc_kill_t;
	logic        clk_sys = 1'b0, clk_link = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, g0 = 1'b0, g1 = 1'b0;
	logic        ana_act = 1'b1, ser_act = 1'b1, f_sh = 1'b0, f_th = 1'b0;
	logic [10:0] reg_addr = 11'h0;
	logic [31:0] reg_wdata = 32'h0, rdata;
	logic [47:0] coeffs = 48'h1234_5678_9abc, trim;
	logic        sup_b = 1'b0, sup_w = 1'b0, h_b, h_w, b_o, b_oe, w_o, w_oe;
	logic        hit, zx, boost, s_dsp, c_dsp, a_en, b_en, par, t_en, byp, sq;
	logic        scp, tsd, pmc, se, st, rx, tx_en;
	logic [5:0]  gain;
	logic [8:0]  half;
	logic [1:0]  tx, a_src, b_src, pre;
	int          fails = 0, checks_done = 0, cyc = 0, tg = 0, tw = 0;
	int          gc[4] = '{0, 51, 52, 63}, hd[4] = '{-153, 0, 3, 36};
	int          bits[8] = '{2, 5, 7, 8, 9, 10, 11, 12};
	arc_row_t rows[6] = '{'{11'h522, 32'hffff_ffff, 32'h0f0f_3f80},
		'{11'h523, 32'hffff_ffff, 32'h0100_1fff},
		'{11'h524, 32'hffff_ffff, 32'h0000_001f},
		'{11'h521, 32'hffff_ffff, 32'h0}, '{11'h525, 32'hffff_ffff, 32'h0},
		'{11'h523, 32'h0, 32'h0}};
	arc_kill_t kl[7] = '{'{13'h008, 4'b0111, 2'b00}, '{13'h008, 4'b1111, 2'b10},
		'{13'h010, 4'b1011, 2'b00}, '{13'h040, 4'b1110, 2'b00},
		'{13'h240, 4'b1110, 2'b10}, '{13'h044, 4'b1101, 2'b00},
		'{13'h004, 4'b1100, 2'b11}};
	logic [4:0] lk[5] = '{5'h1b, 5'h0c, 5'h12, 5'h18, 5'h06};
	logic [3:0] le[5] = '{4'b0011, 4'b0110, 4'b1001, 4'b0000, 4'b1100};
	wire bclk_w = b_oe ? b_o : h_b;
	wire ws_w = w_oe ? w_o : h_w;
	always #10 clk_sys = ~clk_sys;
	always #16 clk_link = ~clk_link;
	always @(posedge bclk_w) tg++;
	always @(ws_w) tw++;
	arc_config_regs u_arc_config_regs (.clk_sys(clk_sys), .rst_n(rst_n),
		.clk_en(clk_en), .clk_link(clk_link), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
		.reg_hit(hit), .gain_pin_zero(g0), .gain_pin_one(g1),
		.analog_active(ana_act), .serial_active(ser_act), .fault_short(f_sh),
		.fault_thermal(f_th), .conv_trim_coeffs(coeffs), .link_bclk_in(bclk_w),
		.link_ws_in(ws_w), .gain_zero_cross_off(zx), .digital_in_gain(gain),
		.digital_gain_half_db(half), .gain_is_boost(boost),
		.serial_to_dsp(s_dsp), .conv_to_dsp(c_dsp), .primary_tx_source(tx),
		.amp_a_source(a_src), .amp_b_source(b_src), .amp_out_a_en(a_en),
		.amp_out_b_en(b_en), .amp_parallel(par), .preamp_gain(pre),
		.conv_trim_enable(t_en), .conv_trim_applied(trim),
		.pulse_correct_bypass(byp), .input_short_quiet(sq),
		.short_protect_off(scp), .thermal_protect_off(tsd),
		.power_mgmt_pll_clock(pmc), .single_edge_modulation(se),
		.port_stereo(st), .port_rx_en(rx), .port_tx_en(tx_en),
		.link_bclk_out(b_o), .link_bclk_oe(b_oe), .link_ws_out(w_o),
		.link_ws_oe(w_oe));
	arc_link_host u_arc_link_host (.clk_link(clk_link), .supply_bclk(sup_b),
		.supply_ws(sup_w), .host_bclk(h_b), .host_ws(h_w));
	task automatic print_verdict();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [10:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask : wr
	task automatic rd(input logic [10:0] a);
		@(negedge clk_sys);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		reg_rd = 1'b0;
	endtask : rd
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk("rdata", rows[i].e, rdata);
			chk("hit", rows[i].e != 0 || rows[i].d == 0, hit);
		end
		$display("test readback done");
		rst_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		rd(`ARC_OFF_MIXER);
		chk("mixer_rst", 32'h0000_3300, rdata);
		rd(`ARC_OFF_ANALOG);
		chk("analog_rst", 32'h0, rdata);
		rd(`ARC_OFF_PORT);
		chk("port_rst", 32'h0, rdata);
		chk("gain_rst", {gain, half, a_en}, {6'd51, 9'h0, 1'b0});
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			wr(`ARC_OFF_MIXER, (i << 24) | ((3 - i) << 26) | (i << 18)
				| (gc[i] << 8) | ((i & 3) << 16) | ((i & 1) << 7));
			wr(`ARC_OFF_ANALOG, 32'h0100_0000 | i);
			chk("amp_a", i, a_src);
			chk("amp_b", 3 - i, b_src);
			chk("tx_src", i == 3 ? 0 : i, tx);
			chk("gain", {gc[i][5:0], 9'(hd[i]), gc[i] > 51}, {gain, half, boost});
			chk("dsp_feed", i, {c_dsp, s_dsp});
			chk("zero_cross", i & 1, zx);
			chk("preamp", i, pre);
			chk("amp_a_en", i != 0, a_en);
		end
		wr(`ARC_OFF_ANALOG, 32'h0);
		g1 = 1'b1;
		repeat (6) @(negedge clk_sys);
		chk("pin_gain", 2'b10, pre);
		$display("test fields done");
		foreach (bits[i]) begin
			wr(`ARC_OFF_ANALOG, 32'h1 << bits[i]);
			chk("ana_bit", 32'h1 << bits[i], {se, pmc, tsd, scp, sq, byp, 1'b0,
				t_en, 2'b00, par, 2'b00});
			chk("trim", bits[i] == 5 ? coeffs : 48'h0, trim);
		end
		wr(`ARC_OFF_MIXER, 32'h0100_0000);
		foreach (kl[i]) begin
			{ana_act, ser_act, f_sh, f_th} = kl[i].in;
			wr(`ARC_OFF_ANALOG, 32'(kl[i].ana));
			repeat (6) @(negedge clk_sys);
			chk("amp_en", kl[i].e, {a_en, b_en});
		end
		$display("test shutdown done");
		foreach (lk[i]) begin
			{sup_b, sup_w} = le[i][3:2];
			wr(`ARC_OFF_PORT, 32'(lk[i]));
			repeat (20) @(negedge clk_sys);
			chk("port", lk[i][2:0], {tx_en, rx, st});
			chk("oe", le[i][1:0], {b_oe, w_oe});
			tg = 0;
			repeat (64) @(posedge clk_link);
			chk("bclk_runs", le[i][3] | le[i][1], tg > 2);
		end
		// word select halves last 32 bit clocks of 8 link clocks each
		wr(`ARC_OFF_PORT, 32'h0000_001b);
		repeat (20) @(negedge clk_sys);
		@(negedge clk_link);
		tw = 0;
		repeat (768) @(negedge clk_link);
		chk("ws_rate", 3, tw);
		$display("test link done");
		print_verdict();
	end
endmodule : tb_top
